// file: src/sfdl_crc16.sv
// Byte-wide CRC16 next-value logic, MSB first
`timescale 1ns/1ps
module sfdl_crc16
  import sfdl_pkg::*;
(
  input wire logic [15:0] crc_in, // Current CRC value
  input wire logic [7:0] data, // Byte folded in, MSB first
  output logic [15:0] crc_out // CRC after the byte
);
  logic [15:0] stage [0:8];

  assign stage[0] = crc_in;

  // ****************************************
  // One shift per data bit
  // ****************************************
  for (genvar i = 0; i < 8; i++)
  begin : g_bit
    logic fb;
    assign fb = stage[i][15] ^ data[7-i];
    assign stage[i+1] = {stage[i][14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000); // [R9]
  end

  assign crc_out = stage[8];
endmodule // sfdl_crc16

// file: src/sfdl_host.sv
// Host controller that drives the secure download mode over the device pins
`timescale 1ns/1ps
module sfdl_host
  import sfdl_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC,
  parameter int unsigned BUSY_MAX_CYCLES = BUSY_MAX_CYC,
  parameter int unsigned RST_CYCLES = RST_CYC,
  parameter int unsigned SCK_HALF = SCK_HALF_CYC
)
(
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic req_valid, // Request offered
  input wire sfdl_pkg::sfdl_req_t req, // Operation, command, length, chunk
  output logic req_ready, // Request taken when high with req_valid
  input wire logic pay_valid, // Payload byte offered
  input wire logic [7:0] pay_data, // Payload byte
  output logic pay_ready, // Payload byte taken when high with pay_valid
  output logic rsp_valid, // One-cycle pulse per status or payload byte
  output logic [7:0] rsp_data, // Received status or payload byte
  output logic done, // One-cycle pulse when an operation ends
  output sfdl_pkg::sfdl_result_t result, // Outcome of the last operation
  output logic in_download, // Device believed to be in download mode
  output logic download_request_pin, // Download request strap to the device
  output logic dev_reset_n, // Device reset, active low
  output logic nss_n, // SPI select, active low
  output logic sck, // SPI clock
  output logic mosi, // SPI data to the device
  input wire logic miso, // SPI data from the device
  input wire logic busy // Device busy line
);
  import sfdl_pkg::*;

  sfdl_host_state_t s_q;
  sfdl_host_state_t s_d;
  logic [1:0] miso_sync_q;
  logic [1:0] busy_sync_q;
  logic spi_done;
  logic [7:0] spi_rx;
  logic [15:0] crc_nx;

  if (BOOT_CYCLES < 1 || BOOT_CYCLES >= (1 << TMR_W) || RST_CYCLES < 1
      || RST_CYCLES >= (1 << TMR_W) || BUSY_MAX_CYCLES < 1
      || BUSY_MAX_CYCLES >= (1 << TMR_W))
  begin : g_check
    $error("Timing counts must lie between 1 and the timer range");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      miso_sync_q <= 2'h0;
      busy_sync_q <= 2'h3;
    end
    else if (ce)
    begin
      miso_sync_q <= {miso_sync_q[0], miso};
      busy_sync_q <= {busy_sync_q[0], busy};
    end
  end

  // ****************************************
  // Serial engine and CRC
  // ****************************************
  sfdl_spi_byte #(
    .HALF_CYCLES(SCK_HALF)
  ) u_spi (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .go(s_q.spi_go),
    .tx(s_q.spi_tx),
    .miso_s(miso_sync_q[1]),
    .rx(spi_rx),
    .done(spi_done),
    .sck(sck),
    .mosi(mosi)
  );

  // Folded one cycle after each byte, well before any CRC byte is sent or checked
  sfdl_crc16 u_crc (
    .crc_in(s_q.crc),
    .data(s_q.last_byte),
    .crc_out(crc_nx)
  );

  // Launch one byte, then wait for the engine to finish it
  function automatic sfdl_host_state_t send(input sfdl_host_state_t s, input logic [7:0] b,
                                            input logic upd, input sfdl_state_t nxt,
                                            input logic fin);
    sfdl_host_state_t r;
    r = s;
    if (!s.launched)
    begin
      r.spi_go = 1'b1;
      r.spi_tx = b;
      r.launched = 1'b1;
      r.last_byte = b;
      r.crc_upd = upd;
    end
    else if (fin)
    begin
      r.launched = 1'b0;
      r.st = nxt;
    end
    return r;
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.spi_go = 1'b0;
    s_d.crc_upd = 1'b0;
    s_d.rsp_valid = 1'b0;
    s_d.done = 1'b0;
    if (s_q.crc_upd)
      s_d.crc = crc_nx; // [R9]
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.req_ready = 1'b1;
        if (req_valid && s_q.req_ready)
        begin
          s_d.req_ready = 1'b0;
          s_d.result = '0;
          s_d.tmr = '0;
          s_d.cmd = req.cmd;
          s_d.len = req.len;
          s_d.chunk = req.chunk;
          case (req.op)
            OP_ENTER:
            begin
              // Strap raised before the reset so it is stable through boot
              s_d.dl_pin = 1'b1; // [R1] [R20]
              s_d.st = ST_RST_ON;
            end
            OP_LEAVE:
            begin
              s_d.dl_pin = 1'b0; // [R20]
              s_d.st = ST_RST_ON;
            end
            OP_XFER:
            begin
              s_d.nss_n = 1'b0;
              s_d.st = ST_WR_DIR;
            end
            default:
            begin
              s_d.done = 1'b1;
            end
          endcase
        end
      end
      ST_RST_ON:
      begin
        s_d.dev_rst_n = 1'b0;
        if (s_q.tmr == TMR_W'(RST_CYCLES))
        begin
          s_d.dev_rst_n = 1'b1;
          s_d.tmr = '0;
          s_d.st = ST_BOOT;
        end
        else
          s_d.tmr = s_q.tmr + 1'b1;
      end
      ST_BOOT:
      begin
        // Pin level counts only while the device starts up
        if (s_q.tmr == TMR_W'(BOOT_CYCLES - 1))
        begin
          s_d.in_dl = s_q.dl_pin; // [R1]
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
        else
          s_d.tmr = s_q.tmr + 1'b1;
      end
      ST_WR_DIR:
      begin
        s_d = send(s_d, DIR_WRITE, 1'b0, ST_WR_HH, spi_done); // [R5] [R23]
        s_d.crc = CRC_INIT; // [R9]
      end
      ST_WR_HH:
      begin
        s_d = send(s_d, {5'h00, s_q.chunk, s_q.len[9:8]}, 1'b1, ST_WR_HL, spi_done); // [R7] [R14]
      end
      ST_WR_HL:
      begin
        s_d = send(s_d, s_q.len[7:0], 1'b1, ST_WR_CMD, spi_done); // [R8]
      end
      ST_WR_CMD:
      begin
        s_d = send(s_d, s_q.cmd, 1'b1, (s_q.len > 10'h001) ? ST_WR_PAY : ST_WR_CH, spi_done);
        s_d.cnt = '0;
      end
      ST_WR_PAY:
      begin
        // Payload layout is the user's concern
        if (!s_q.launched)
        begin
          s_d.pay_ready = 1'b1;
          if (s_q.pay_ready && pay_valid)
          begin
            s_d.pay_ready = 1'b0;
            s_d = send(s_d, pay_data, 1'b1, ST_WR_PAY, 1'b0); // [R12] [R13]
          end
        end
        else if (spi_done)
        begin
          s_d.launched = 1'b0;
          s_d.cnt = s_q.cnt + 11'h001;
          if (s_q.cnt + 11'h001 == 11'(s_q.len) - 11'h001) // [R8]
            s_d.st = ST_WR_CH;
        end
      end
      ST_WR_CH:
      begin
        s_d = send(s_d, s_q.crc[15:8], 1'b0, ST_WR_CL, spi_done); // [R23]
      end
      ST_WR_CL:
      begin
        s_d = send(s_d, s_q.crc[7:0], 1'b0, ST_GAP, spi_done); // [R23]
        if (s_q.launched && spi_done)
        begin
          s_d.nss_n = 1'b1;
          s_d.tmr = '0;
        end
      end
      ST_GAP:
      begin
        // Give the device time to raise busy before it is trusted
        if (s_q.tmr == TMR_W'(BUSY_SETTLE_CYC - 1))
        begin
          s_d.tmr = '0;
          s_d.st = ST_BUSY;
        end
        else
          s_d.tmr = s_q.tmr + 1'b1;
      end
      ST_BUSY:
      begin
        if (!busy_sync_q[1]) // [R24]
        begin
          s_d.nss_n = 1'b0;
          s_d.st = ST_RD_DIR;
        end
        else if (s_q.tmr == TMR_W'(BUSY_MAX_CYCLES - 1))
        begin
          s_d.result.timeout = 1'b1;
          s_d.done = 1'b1;
          s_d.tmr = '0;
          s_d.st = ST_END;
        end
        else
          s_d.tmr = s_q.tmr + 1'b1;
      end
      ST_RD_DIR:
      begin
        s_d = send(s_d, DIR_READ, 1'b0, ST_RD, spi_done); // [R6]
        s_d.crc = CRC_INIT;
        s_d.cnt = '0;
      end
      ST_RD:
      begin
        if (!s_q.launched)
        begin
          s_d.spi_go = 1'b1;
          s_d.spi_tx = READ_FILL;
          s_d.launched = 1'b1;
        end
        else if (spi_done)
        begin
          s_d.launched = 1'b0;
          s_d.cnt = s_q.cnt + 11'h001;
          s_d.last_byte = spi_rx;
          if (s_q.cnt == 11'h000)
          begin
            s_d.crc_upd = 1'b1;
            s_d.len[9:8] = spi_rx[1:0]; // [R7]
            s_d.chunk = spi_rx[CHUNK_BIT-8]; // [R14]
          end
          else if (s_q.cnt == 11'h001)
          begin
            s_d.crc_upd = 1'b1;
            s_d.len[7:0] = spi_rx;
          end
          else if (s_q.cnt < 11'(s_q.len) + 11'h002) // [R8]
          begin
            s_d.crc_upd = 1'b1;
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = spi_rx;
            if (s_q.cnt == 11'h002)
            begin
              s_d.result.status = spi_rx;
              // Device stays in download mode after an aborted session
              if (spi_rx == STAT_ABORTED) // [R22] [R4]
              begin
                s_d.result.aborted = 1'b1;
                s_d.in_dl = 1'b1;
              end
            end
          end
          else if (s_q.cnt == 11'(s_q.len) + 11'h002)
            s_d.crc_hi = spi_rx; // [R23]
          else
          begin
            s_d.result.crc_ok = ({s_q.crc_hi, spi_rx} == s_q.crc); // [R9]
            s_d.result.len = s_q.len;
            s_d.result.chunk = s_q.chunk;
            s_d.nss_n = 1'b1;
            s_d.done = 1'b1;
            s_d.tmr = '0;
            s_d.st = ST_END;
          end
        end
      end
      ST_END:
      begin
        s_d.nss_n = 1'b1;
        if (s_q.tmr == TMR_W'(NSS_GAP_CYC - 1))
        begin
          s_d.tmr = '0;
          s_d.st = ST_IDLE;
        end
        else
          s_d.tmr = s_q.tmr + 1'b1;
      end
      default:
      begin
        s_d.st = ST_IDLE;
        s_d.launched = 1'b0;
        s_d.nss_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.crc <= CRC_INIT;
      s_q.dev_rst_n <= 1'b1;
      s_q.nss_n <= 1'b1;
    end
    else if (ce)
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign req_ready = s_q.req_ready;
  assign pay_ready = s_q.pay_ready;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_data = s_q.rsp_data;
  assign done = s_q.done;
  assign result = s_q.result;
  assign in_download = s_q.in_dl;
  assign download_request_pin = s_q.dl_pin;
  assign dev_reset_n = s_q.dev_rst_n;
  assign nss_n = s_q.nss_n;
endmodule // sfdl_host

// file: src/sfdl_pkg.sv
// Constants, carrier types and state layouts for the firmware download host controller
// How it works
// [R1] Download mode entered only if request pin is high while the device boots.
// [R2] After boot the device ignores the request pin level for download purposes.
// [R3] In download mode the device accepts only download commands.
// [R4] After a failed download the device stays in download mode until success.
// [R5] Host write frame: 0x7F, two-byte header, command, payload, CRC16.
// [R6] Read frame: host sends 0xFF; device returns header, status, payload, CRC16.
// [R7] Header: length in bits 0-9, chunk flag bit 10, bits 11-15 reserved.
// [R8] Length counts command or status plus payload; CRC bytes excluded.
// [R9] CRC16 polynomial 0x1021 preset 0xFFFF, generated and checked by both.
// [R10] Device decodes 0xF0 reset, 0xF1 version, 0xF4 unique serial; others reserved.
// [R11] Command 0xC0 is the signed block write into internal memory.
// [R12] Signed write payload: 3-byte address, 2-byte size, up to 512 data, 32 hash.
// [R13] First write carries version, hash, signature; middle carry hash; last none.
// [R14] A command and payload may span frames; chunk flag marks more fragments.
// [R15] Device rejects updates whose 8-bit major version is below the installed one.
// [R16] Device aborts download on reset, bad signature, broken chain, framing errors.
// [R17] Device never overwrites firmware before authenticity and integrity are verified.
// [R18] Device refuses integrity check while a session is open.
// [R19] Completed update reloads user settings and radio configuration with defaults.
// [R20] Host order: raise pin, reset, download, integrity check, reset again.
// [R21] Status zero means success; any other value is an error.
// [R22] After an unclean download every command is answered with 0x2A only.
// [R23] CRC covers header and frame bytes, not direction byte; sent MSB first.
// [R24] Device drives busy while processing; host waits for release before reading.
package sfdl_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [7:0] DIR_WRITE = 8'h7F;
  localparam logic [7:0] DIR_READ = 8'hFF;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam int LEN_W = 10;
  localparam int CHUNK_BIT = 10;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_QUERY_VERSION = 8'hF1;
  localparam logic [7:0] CMD_READ_UNIQUE_SERIAL = 8'hF4;
  localparam logic [7:0] CMD_SIGNED_WRITE = 8'hC0;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_ABORTED = 8'h2A;
  localparam int WRITE_ADDR_BYTES = 3;
  localparam int WRITE_SIZE_BYTES = 2;
  localparam int WRITE_MAX_DATA = 512;
  localparam int WRITE_HASH_BYTES = 32;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RST_NS = 10_000;
  localparam int T_BOOT_NS = 2_000_000;
  localparam int T_NSS_GAP_NS = 1_000;
  localparam int T_BUSY_SETTLE_NS = 1_000;
  localparam int T_BUSY_MAX_NS = 100_000_000;
  localparam int T_SCK_HALF_NS = 72;
  localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CYC = (T_BOOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NSS_GAP_CYC = (T_NSS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_SETTLE_CYC = (T_BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_MAX_CYC = T_BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC = (T_SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 24;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [14:0] {
    ST_IDLE = 15'h0001,
    ST_RST_ON = 15'h0002,
    ST_BOOT = 15'h0004,
    ST_WR_DIR = 15'h0008,
    ST_WR_HH = 15'h0010,
    ST_WR_HL = 15'h0020,
    ST_WR_CMD = 15'h0040,
    ST_WR_PAY = 15'h0080,
    ST_WR_CH = 15'h0100,
    ST_WR_CL = 15'h0200,
    ST_GAP = 15'h0400,
    ST_BUSY = 15'h0800,
    ST_RD_DIR = 15'h1000,
    ST_RD = 15'h2000,
    ST_END = 15'h4000
  } sfdl_state_t;

  typedef enum logic [1:0] {
    OP_ENTER = 2'h0,
    OP_LEAVE = 2'h1,
    OP_XFER = 2'h2
  } sfdl_op_t;

  typedef struct packed {
    sfdl_op_t op;
    logic [7:0] cmd;
    logic [LEN_W-1:0] len;
    logic chunk;
  } sfdl_req_t;

  typedef struct packed {
    logic [7:0] status;
    logic [LEN_W-1:0] len;
    logic chunk;
    logic crc_ok;
    logic aborted;
    logic timeout;
  } sfdl_result_t;

  typedef struct packed {
    logic active;
    logic [7:0] tmr;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [7:0] rx;
    logic sck;
    logic mosi;
    logic done;
  } sfdl_spi_state_t;

  typedef struct packed {
    sfdl_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [10:0] cnt;
    logic [LEN_W-1:0] len;
    logic chunk;
    logic [7:0] cmd;
    logic launched;
    logic spi_go;
    logic [7:0] spi_tx;
    logic [7:0] last_byte;
    logic crc_upd;
    logic [15:0] crc;
    logic [7:0] crc_hi;
    logic dl_pin;
    logic dev_rst_n;
    logic nss_n;
    logic req_ready;
    logic pay_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic done;
    logic in_dl;
    sfdl_result_t result;
  } sfdl_host_state_t;

endpackage

// file: src/sfdl_spi_byte.sv
// SPI mode 0 byte shifter; the clock is divided from ref_clk
`timescale 1ns/1ps
module sfdl_spi_byte
  import sfdl_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = SCK_HALF_CYC
)
(
  input wire logic ref_clk, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic go, // Start one byte
  input wire logic [7:0] tx, // Byte to shift out
  input wire logic miso_s, // Synchronised data from the device
  output logic [7:0] rx, // Byte shifted in
  output logic done, // One-cycle pulse at byte end
  output logic sck, // Serial clock
  output logic mosi // Serial data to the device
);
  import sfdl_pkg::*;

  sfdl_spi_state_t s_q;
  sfdl_spi_state_t s_d;

  if (HALF_CYCLES < 1 || HALF_CYCLES > 256)
  begin : g_check
    $error("HALF_CYCLES must lie in 1..256");
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.active)
    begin
      if (go)
      begin
        s_d.active = 1'b1;
        s_d.tmr = 8'h00;
        s_d.bitn = 3'h0;
        s_d.mosi = tx[7];
        s_d.sh = {tx[6:0], 1'b0};
        s_d.sck = 1'b0;
      end
    end
    else if (s_q.tmr != 8'(HALF_CYCLES - 1))
    begin
      s_d.tmr = s_q.tmr + 8'h01;
    end
    else
    begin
      s_d.tmr = 8'h00;
      if (!s_q.sck)
      begin
        // Sample on the rising edge
        s_d.sck = 1'b1;
        s_d.rx = {s_q.rx[6:0], miso_s};
      end
      else
      begin
        s_d.sck = 1'b0;
        if (s_q.bitn == 3'h7)
        begin
          s_d.active = 1'b0;
          s_d.done = 1'b1;
        end
        else
        begin
          s_d.mosi = s_q.sh[7];
          s_d.sh = {s_q.sh[6:0], 1'b0};
          s_d.bitn = s_q.bitn + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  assign rx = s_q.rx;
  assign done = s_q.done;
  assign sck = s_q.sck;
  assign mosi = s_q.mosi;
endmodule // sfdl_spi_byte

// file: verification/sfdl_dev_model.sv
// Behavioural model of the device in secure download mode
`timescale 1ns/1ps
module sfdl_dev_model
  import sfdl_pkg::*;
(
  input wire logic download_request_pin, // Strap
  input wire logic dev_reset_n, // Reset, active low
  input wire logic nss_n, // Select
  input wire logic sck, // Serial clock
  input wire logic mosi, // Serial data in
  input wire logic abort_mode, // Previous download unclean
  input wire logic stall, // Holds busy while high
  output logic miso, // Serial data out
  output logic busy // Processing a frame
);
  logic dl_mode = 1'b0;
  logic [7:0] sh;
  logic [7:0] st;
  logic [15:0] c;
  logic [7:0] q[$], wq[$], rq[$];
  int tot, idx;
  function automatic logic [15:0] crc8(input logic [15:0] v, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      v = {v[14:0], 1'b0} ^ ((v[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return v;
  endfunction
  initial
  begin
    miso = 1'b0;
    busy = 1'b0;
  end
  // Strap counts only at reset release
  always @(posedge dev_reset_n)
    dl_mode = download_request_pin | abort_mode;
  // Released line inverts so a stale bit cannot pass
  always @(negedge nss_n)
  begin
    tot = 0;
    q = {};
    miso = ~miso;
  end
  always @(posedge sck)
    if (!nss_n)
    begin
      sh = {sh[6:0], mosi};
      tot++;
      if (tot % 8 == 0)
        q.push_back(sh);
    end
  always @(negedge sck)
    if (!nss_n)
    begin
      idx = tot / 8 - 1;
      miso = (idx >= 0 && idx < rq.size()) ? rq[idx][7 - tot % 8] : ~miso;
    end
  always @(posedge nss_n)
  begin
    miso = ~miso;
    if (q.size() >= 5 && q[0] == DIR_WRITE)
    begin
      wq = q;
      busy = 1'b1;
      c = CRC_INIT;
      for (int i = 1; i < q.size() - 2; i++)
        c = crc8(c, q[i]);
      st = (c == {q[q.size()-2], q[q.size()-1]} && {q[1][1:0], q[2]} == q.size() - 5
          && dl_mode && q[3] inside {CMD_RESET, CMD_QUERY_VERSION, CMD_READ_UNIQUE_SERIAL,
          CMD_SIGNED_WRITE}) ? STAT_OK : 8'h01;
      if (abort_mode)
        rq = {8'h00, 8'h01, STAT_ABORTED};
      else
        rq = {8'h00, 8'h04, st, 8'h00, 8'h00, 8'h00};
      c = CRC_INIT;
      foreach (rq[i])
        c = crc8(c, rq[i]);
      rq = {rq, c[15:8], c[7:0]};
      #600;
      wait (!stall);
      busy = 1'b0;
    end
  end
endmodule // sfdl_dev_model

// file: verification/sfdl_host_sva.sv
// Port assertions for the download host controller
`timescale 1ns/1ps
module sfdl_host_sva
  import sfdl_pkg::*;
#(
  parameter int unsigned RST_CYCLES = RST_CYC
)
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire sfdl_pkg::sfdl_req_t req, // Request
  input wire logic req_valid, // Offered
  input wire logic req_ready, // Taken
  input wire logic rsp_valid, // Byte strobe
  input wire logic download_request_pin, // Strap
  input wire logic dev_reset_n, // Device reset
  input wire logic nss_n, // Select
  input wire logic sck, // Serial clock
  input wire logic mosi, // Serial data
  input wire logic busy // Device busy
);
  int unsigned low_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Device reset width counter
  // ****
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_q <= 0;
    else if (dev_reset_n)
      low_q <= 0;
    else
      low_q <= low_q + 1;
  end
  sequence s_enter_take;
    req_valid && req_ready && req.op == OP_ENTER;
  endsequence
  sequence s_strap_reset;
    ##[1:2] (download_request_pin && !dev_reset_n);
  endsequence
  a_enter_order: assert property (s_enter_take |-> s_strap_reset)
    else $error("no strap and reset after enter");
  a_strap_hold: assert property (!dev_reset_n |=> $stable(download_request_pin))
    else $error("strap moved during reset");
  a_reset_width: assert property ($rose(dev_reset_n) |-> low_q >= RST_CYCLES)
    else $error("device reset too short");
  a_sck_idle: assert property (nss_n |-> !sck)
    else $error("clock outside frame");
  a_sck_half: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
    else $error("clock high phase wrong");
  a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data moved while clock high");
  a_frame_waits: assert property ($fell(nss_n) |-> !busy && $past(!busy))
    else $error("frame while busy");
  a_rsp_in_frame: assert property (rsp_valid |-> !nss_n)
    else $error("response outside frame");
  a_frame_gap: assert property ($rose(nss_n) |-> nss_n[*8])
    else $error("select gap too short");
  a_idle_quiet: assert property (req_ready |-> nss_n && dev_reset_n)
    else $error("ready while active");
endmodule // sfdl_host_sva

bind sfdl_host sfdl_host_sva #(.RST_CYCLES(RST_CYCLES)) i_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .download_request_pin(download_request_pin),
  .dev_reset_n(dev_reset_n), .nss_n(nss_n), .sck(sck), .mosi(mosi), .busy(busy));

// file: verification/testbench.sv
// Self-checking bench for the download host controller
`timescale 1ns/1ps
module testbench;
  import sfdl_pkg::*;
  localparam logic [7:0] F0_EXP [9] = '{8'h7F, 8'h00, 8'h04, 8'hF0, 8'h00, 8'h00, 8'h00,
    8'h18, 8'h5B};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  sfdl_req_t req = '0;
  logic pay_valid = 1'b0;
  logic [7:0] pay_data = 8'h00;
  logic abort_mode = 1'b0;
  logic stall = 1'b0;
  logic req_ready, pay_ready, rsp_valid, done, in_download, download_request_pin;
  logic dev_reset_n, nss_n, sck, mosi, miso, busy;
  logic [7:0] rsp_data;
  sfdl_result_t result;
  int n_mismatch = 0;
  int samples_checked = 0;
  int nr;
  always #5 ref_clk = ~ref_clk;
  sfdl_host #(.BOOT_CYCLES(50), .BUSY_MAX_CYCLES(2000), .RST_CYCLES(10)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done), .result(result),
    .in_download(in_download), .download_request_pin(download_request_pin),
    .dev_reset_n(dev_reset_n), .nss_n(nss_n), .sck(sck), .mosi(mosi), .miso(miso), .busy(busy));
  sfdl_dev_model i_dev (
    .download_request_pin(download_request_pin), .dev_reset_n(dev_reset_n), .nss_n(nss_n),
    .sck(sck), .mosi(mosi), .abort_mode(abort_mode), .stall(stall), .miso(miso), .busy(busy));
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Hand over, feed payload, count response bytes
  task automatic run(input sfdl_op_t o, input logic [7:0] c, input logic [9:0] l,
      input logic ch, input logic [7:0] pv);
    int k;
    int i;
    k = 0;
    req <= '{op: o, cmd: c, len: l, chunk: ch};
    req_valid <= 1'b1;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++k < 500);
    req_valid <= 1'b0;
    pay_valid <= (o == OP_XFER && l > 1);
    pay_data <= pv;
    for (i = 1; o == OP_XFER && i < l; i++)
      do @(posedge ref_clk); while (pay_ready !== 1'b1 && ++k < 9000);
    pay_valid <= 1'b0;
    nr = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
      nr += (rsp_valid === 1'b1);
    end
    while (done !== 1'b1 && k < 20000);
    if (k >= 20000)
    begin
      chk(16'h0000, 16'h0001);
      test_done();
    end
  endtask
  task automatic t_enter;
    run(OP_ENTER, 8'h00, 10'd0, 1'b0, 8'h00);
    chk(in_download, 1'b1);
    chk(i_dev.dl_mode, 1'b1);
  endtask
  task automatic t_reset_frame;
    run(OP_XFER, CMD_RESET, 10'd4, 1'b0, 8'h00);
    foreach (F0_EXP[i])
      chk(i_dev.wq[i], F0_EXP[i]);
    chk(result.status, STAT_OK);
    chk(result.crc_ok, 1'b1);
    chk(nr, 4);
    chk(result.len, 10'h004);
  endtask
  task automatic t_cmd_set;
    logic [7:0] cmds [3];
    cmds = '{CMD_QUERY_VERSION, CMD_READ_UNIQUE_SERIAL, CMD_SIGNED_WRITE};
    foreach (cmds[i])
    begin
      run(OP_XFER, cmds[i], 10'd4, i == 2, 8'hA5);
      chk(result.status, STAT_OK);
      chk(i_dev.wq[4], 8'hA5);
      chk(i_dev.wq[1][2], i == 2);
    end
    run(OP_XFER, 8'hA5, 10'd4, 1'b0, 8'h3C);
    chk(result.status, 8'h01);
  endtask
  task automatic t_busy;
    stall <= 1'b1;
    run(OP_XFER, CMD_QUERY_VERSION, 10'd4, 1'b0, 8'h00);
    chk(result.timeout, 1'b1);
    stall <= 1'b0;
    @(posedge ref_clk);
    stall <= 1'b1;
    fork
      begin
        repeat (1500) @(posedge ref_clk);
        stall <= 1'b0;
      end
    join_none
    run(OP_XFER, CMD_QUERY_VERSION, 10'd4, 1'b0, 8'h00);
    chk(result.timeout, 1'b0);
    chk(result.status, STAT_OK);
  endtask
  task automatic t_aborted;
    abort_mode <= 1'b1;
    run(OP_XFER, CMD_QUERY_VERSION, 10'd4, 1'b0, 8'h00);
    chk(result.status, STAT_ABORTED);
    chk(result.aborted, 1'b1);
    chk(nr, 1);
    chk(rsp_data, STAT_ABORTED);
    chk(in_download, 1'b1);
    abort_mode <= 1'b0;
  endtask
  task automatic t_leave;
    run(OP_LEAVE, 8'h00, 10'd0, 1'b0, 8'h00);
    chk(in_download, 1'b0);
    chk(i_dev.dl_mode, 1'b0);
    run(OP_XFER, CMD_QUERY_VERSION, 10'd4, 1'b0, 8'h00);
    chk(result.status, 8'h01);
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_enter();
    t_reset_frame();
    t_cmd_set();
    t_busy();
    t_aborted();
    t_leave();
    test_done();
  end
endmodule // testbench
